// ---- common/spi_front_pkg.sv ----
package spi_front_pkg;
   // Instruction codes that change the lane count
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OP_QUAD_IO = 8'hEB;

   // Lanes of the io bundle that double as protect and pause pins
   localparam int LANE_PROTECT = 2;
   localparam int LANE_PAUSE = 3;

   // Reset values
   localparam logic [2:0] BIT_CNT_RST = 3'h0;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [7:0] IDLE_FILL = 8'hFF;
   localparam logic [3:0] LANES_OFF = 4'hF;

   typedef enum logic [1:0] {
      LANES_ONE = 2'b00,
      LANES_TWO = 2'b01,
      LANES_FOUR = 2'b10
   } lanes_e;

   typedef enum logic [0:0] {
      PH_CMD = 1'b0,
      PH_BODY = 1'b1
   } phase_e;

   typedef struct packed {
      logic first;
      logic [7:0] data;
   } rx_s;

   typedef struct packed {
      lanes_e in_lanes;
      lanes_e out_lanes;
   } lane_cfg_s;

   localparam lane_cfg_s CFG_RST = '{in_lanes: LANES_ONE, out_lanes: LANES_ONE};

   function automatic logic [2:0] lane_step(input lanes_e l);
      case (l)
         LANES_TWO: lane_step = 3'h2;
         LANES_FOUR: lane_step = 3'h4;
         default: lane_step = 3'h1;
      endcase
   endfunction
endpackage

// ---- core/serial_flash_spi_front_end.sv ----
`timescale 1ns/10ps

// Overview of operation
// - Deselected: every output lane floats
// - Selected: take instruction bytes, return data
// - Chip-select release never cancels running internal cycle
// - Nothing accepted before first select rising edge (release)
// - Single lane: sample serial_in on rising edges
// - Single lane: change serial_out on falling edges
// - Multi lane: capture rising, drive falling
// - Works with clock idling low or high
// - Codes 3Bh/BBh use io_lane0 and io_lane1
// - Codes 6Bh/EBh use all four lanes
// - Quad honoured only with quad_lane_enable set
// - Protect pin blocks status writes only with status_protect_bit0 set, unless quad
// - Pause only while selected
// - Pause starts now if clock low, else next fall
// - Pause ends now if clock low, else next fall
// - Paused: outputs float, clock and input ignored
// - Paused: shift state kept intact
// - No pause during quad transfers
module serial_flash_spi_front_end (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_n,
   input wire logic quad_lane_enable,
   input wire logic status_protect_bit0,
   output logic status_write_blocked,
   output logic selected,
   output logic frame_end,
   output logic rx_valid,
   output spi_front_pkg::rx_s rx_word,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);

   // ---------------- link clock domain ----------------
   // Releasing select clears the whole frame; the toggles survive it.
   wire link_rst_n = nrst & ~cs_n;

   logic armed_r;
   logic qe_m_r;
   logic qe_s_r;
   logic tx_m_r;
   logic tx_s_r;
   logic tx_ack_r;
   logic rx_tgl_r;
   spi_front_pkg::rx_s rx_hold_r;
   spi_front_pkg::phase_e phase_r;
   spi_front_pkg::lane_cfg_s cfg_r;
   spi_front_pkg::lane_cfg_s cfg_nxt;
   logic [2:0] in_cnt_r;
   logic [7:0] in_sh_r;
   logic [7:0] in_nxt;
   logic [2:0] out_cnt_r;
   logic [7:0] out_sh_r;
   logic out_active_r;
   logic hold_rise_r;
   logic [7:0] tx_buf_r;
   logic tx_tgl_r;

   // Set by the first select release after power-up
   always_ff @(posedge cs_n or negedge nrst) begin
      if (!nrst) begin
         armed_r <= 1'b0;
      end else begin
         armed_r <= 1'b1;
      end
   end

   // Quad enable is static config; a two-stage sync on the link clock
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         qe_m_r <= 1'b0;
         qe_s_r <= 1'b0;
         tx_m_r <= 1'b0;
         tx_s_r <= 1'b0;
      end else begin
         qe_m_r <= quad_lane_enable;
         qe_s_r <= qe_m_r;
         tx_m_r <= tx_tgl_r;
         tx_s_r <= tx_m_r;
      end
   end

   wire quad_now = (cfg_r.in_lanes == spi_front_pkg::LANES_FOUR) ||
                   (cfg_r.out_lanes == spi_front_pkg::LANES_FOUR);
   wire pause_ok = ~qe_s_r & ~quad_now;
   wire hold_now = ~io_in[spi_front_pkg::LANE_PAUSE] & pause_ok;
   // Pause pin acts asynchronously by intent: with the clock low it must
   // take effect at once, so it cannot wait for a synchroniser.
   // With the clock high the level seen at the last rise stands until the next
   // fall. Each edge is gated by the level that stood just before it, so no
   // edge races the combinational pause term.
   wire paused = ~cs_n & (sck ? hold_rise_r : hold_now);
   wire run_rise = armed_r & ~hold_now;
   wire run_fall = armed_r & ~hold_rise_r;

   wire [2:0] in_step = spi_front_pkg::lane_step(cfg_r.in_lanes);
   wire [2:0] out_step = spi_front_pkg::lane_step(cfg_r.out_lanes);
   wire [2:0] in_cnt_nxt = 3'(in_cnt_r + in_step);
   wire byte_done = (in_cnt_nxt == spi_front_pkg::BIT_CNT_RST);

   always_comb begin
      case (cfg_r.in_lanes)
         spi_front_pkg::LANES_TWO: in_nxt = {in_sh_r[5:0], io_in[1:0]};
         spi_front_pkg::LANES_FOUR: in_nxt = {in_sh_r[3:0], io_in[3:0]};
         default: in_nxt = {in_sh_r[6:0], io_in[0]};
      endcase
   end

   always_comb begin
      cfg_nxt = spi_front_pkg::CFG_RST;
      case (in_nxt)
         spi_front_pkg::OP_DUAL_OUT: begin
            cfg_nxt.out_lanes = spi_front_pkg::LANES_TWO;
         end
         spi_front_pkg::OP_DUAL_IO: begin
            cfg_nxt.in_lanes = spi_front_pkg::LANES_TWO;
            cfg_nxt.out_lanes = spi_front_pkg::LANES_TWO;
         end
         spi_front_pkg::OP_QUAD_OUT: begin
            if (qe_s_r) begin
               cfg_nxt.out_lanes = spi_front_pkg::LANES_FOUR;
            end
         end
         spi_front_pkg::OP_QUAD_IO: begin
            if (qe_s_r) begin
               cfg_nxt.in_lanes = spi_front_pkg::LANES_FOUR;
               cfg_nxt.out_lanes = spi_front_pkg::LANES_FOUR;
            end
         end
         default: begin
            cfg_nxt = spi_front_pkg::CFG_RST;
         end
      endcase
   end

   // Inbound shifter; either clock idle level works since only edges count
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         in_cnt_r <= spi_front_pkg::BIT_CNT_RST;
         in_sh_r <= spi_front_pkg::SHIFT_RST;
         phase_r <= spi_front_pkg::PH_CMD;
         cfg_r <= spi_front_pkg::CFG_RST;
      end else if (run_rise) begin
         in_cnt_r <= in_cnt_nxt;
         in_sh_r <= in_nxt;
         if (byte_done && phase_r == spi_front_pkg::PH_CMD) begin
            phase_r <= spi_front_pkg::PH_BODY;
            cfg_r <= cfg_nxt;
         end
      end
   end

   // Byte hand-off toggle; never reset by select so no false event appears
   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         rx_tgl_r <= 1'b0;
         rx_hold_r <= '0;
      end else if (run_rise && !cs_n && byte_done) begin
         rx_tgl_r <= ~rx_tgl_r;
         rx_hold_r <= '{first: (phase_r == spi_front_pkg::PH_CMD), data: in_nxt};
      end
   end

   // Pause level frozen at each rise for the high phase of the clock
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         hold_rise_r <= 1'b0;
      end else begin
         hold_rise_r <= hold_now;
      end
   end

   wire tx_new = (tx_s_r != tx_ack_r);
   wire out_load = (out_cnt_r == spi_front_pkg::BIT_CNT_RST);
   wire body = (phase_r == spi_front_pkg::PH_BODY);

   // Outbound shifter changes on falling edges only
   always_ff @(negedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         out_cnt_r <= spi_front_pkg::BIT_CNT_RST;
         out_sh_r <= spi_front_pkg::IDLE_FILL;
         out_active_r <= 1'b0;
      end else if (run_fall && body) begin
         if (out_load) begin
            out_cnt_r <= out_step;
            out_sh_r <= tx_new ? tx_buf_r : spi_front_pkg::IDLE_FILL;
            out_active_r <= out_active_r | tx_new;
         end else begin
            out_cnt_r <= 3'(out_cnt_r + out_step);
            out_sh_r <= out_sh_r << out_step;
         end
      end
   end

   always_ff @(negedge sck or negedge nrst) begin
      if (!nrst) begin
         tx_ack_r <= 1'b0;
      end else if (run_fall && !cs_n && body && out_load) begin
         tx_ack_r <= tx_s_r;
      end
   end

   logic [3:0] lane_mask;
   logic [3:0] lane_data;
   always_comb begin
      case (cfg_r.out_lanes)
         spi_front_pkg::LANES_TWO: begin
            lane_mask = 4'h3;
            lane_data = {2'b00, out_sh_r[7:6]};
         end
         spi_front_pkg::LANES_FOUR: begin
            lane_mask = 4'hF;
            lane_data = out_sh_r[7:4];
         end
         default: begin
            lane_mask = 4'h2;
            lane_data = {2'b00, out_sh_r[7], 1'b0};
         end
      endcase
   end

   wire drive = ~cs_n & out_active_r & ~paused;
   assign io_oe_n = drive ? ~lane_mask : spi_front_pkg::LANES_OFF;
   assign io_out = lane_data & lane_mask;

   // ---------------- system clock domain ----------------
   logic cs_m_r;
   logic cs_s_r;
   logic cs_d_r;
   logic rx_m_r;
   logic rx_s_r;
   logic rx_d_r;
   logic ack_m_r;
   logic ack_s_r;
   logic wp_m_r;
   logic wp_s_r;
   logic rx_valid_r;
   spi_front_pkg::rx_s rx_word_r;
   logic blocked_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         rx_m_r <= 1'b0;
         rx_s_r <= 1'b0;
         rx_d_r <= 1'b0;
         ack_m_r <= 1'b0;
         ack_s_r <= 1'b0;
         wp_m_r <= 1'b1;
         wp_s_r <= 1'b1;
      end else begin
         cs_m_r <= cs_n;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         rx_m_r <= rx_tgl_r;
         rx_s_r <= rx_m_r;
         rx_d_r <= rx_s_r;
         ack_m_r <= tx_ack_r;
         ack_s_r <= ack_m_r;
         wp_m_r <= io_in[spi_front_pkg::LANE_PROTECT];
         wp_s_r <= wp_m_r;
      end
   end

   wire rx_event = rx_s_r ^ rx_d_r;

   // Byte word is held in the link domain until the next byte, so it is
   // stable when the toggle arrives here.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_valid_r <= 1'b0;
         rx_word_r <= '0;
         blocked_r <= 1'b0;
      end else begin
         rx_valid_r <= rx_event;
         if (rx_event) begin
            rx_word_r <= rx_hold_r;
         end
         blocked_r <= status_protect_bit0 & ~wp_s_r & ~quad_lane_enable;
      end
   end

   assign tx_ready = (tx_tgl_r == ack_s_r);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_tgl_r <= 1'b0;
         tx_buf_r <= spi_front_pkg::IDLE_FILL;
      end else if (tx_valid && tx_ready) begin
         tx_tgl_r <= ~tx_tgl_r;
         tx_buf_r <= tx_data;
      end
   end

   // Frame end only informs; any internal cycle keeps running
   assign frame_end = cs_s_r & ~cs_d_r;
   assign selected = ~cs_s_r;
   assign rx_valid = rx_valid_r;
   assign rx_word = rx_word_r;
   assign status_write_blocked = blocked_r;

endmodule

// ---- tb/flash_front_checker.sv ----
`timescale 1ns/10ps
module flash_front_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic [3:0] io_oe_n,
   input wire logic quad_lane_enable,
   input wire logic status_protect_bit0,
   input wire logic status_write_blocked,
   input wire logic selected,
   input wire logic frame_end,
   input wire logic rx_valid,
   input wire spi_front_pkg::rx_s rx_word,
   input wire logic tx_valid,
   input wire logic tx_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_float; cs_n |-> io_oe_n == 4'hF; endproperty
   a_float: assert property (p_float) else $error("lane driven unselected");
   property p_sel; !cs_n [*4] |-> selected; endproperty
   a_sel: assert property (p_sel) else $error("not selected");
   property p_abort; $rose(cs_n) |-> ##[1:5] frame_end; endproperty
   a_abort: assert property (p_abort) else $error("no frame end");
   property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("long rx pulse");
   property p_rx_hold; !rx_valid |-> $stable(rx_word); endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx word moved");
   // Clock low makes the pause immediate, so the lanes must float at once
   property p_pause; !cs_n && !sck && !io_in[3] && !quad_lane_enable |-> io_oe_n == 4'hF;
   endproperty
   a_pause: assert property (p_pause) else $error("driven in pause");
   property p_wp; (status_protect_bit0 && !io_in[2] && !quad_lane_enable) [*5]
      |-> status_write_blocked; endproperty
   a_wp: assert property (p_wp) else $error("not blocked");
   property p_quad; quad_lane_enable [*2] |-> !status_write_blocked; endproperty
   a_quad: assert property (p_quad) else $error("blocked in quad");
   property p_take; tx_valid && tx_ready |=> !tx_ready; endproperty
   a_take: assert property (p_take) else $error("tx not taken");
endmodule
bind serial_flash_spi_front_end flash_front_checker u_chk (.clk, .nrst, .sck, .cs_n,
   .io_in, .io_oe_n, .quad_lane_enable, .status_protect_bit0, .status_write_blocked,
   .selected, .frame_end, .rx_valid, .rx_word, .tx_valid, .tx_ready);

// ---- tb/flash_host.sv ----
`timescale 1ns/10ps
module flash_host (
   output logic sck,
   output logic cs_n,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out
);
   logic [3:0] d = 4'h0;
   logic wp_n = 1'b1;
   logic pause_n = 1'b1;
   logic pol = 1'b0;
   int ni = 1;
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
   end
   // Lanes 2 and 3 stay protect and pause pins unless four lanes carry data
   assign io_in = (ni == 4) ? d : {pause_n, wp_n, d[1:0]};
   task automatic start(input logic p);
      pol = p;
      sck = p;
      #7.5 cs_n = 1'b0;
      #7.5;
   endtask
   task automatic xfer(input logic [7:0] b, input int n_in, n_out, n_clk,
                       output logic [7:0] r);
      ni = n_in;
      r = 8'h00;
      for (int k = 0; k < n_clk; k++) begin
         sck = 1'b0;
         for (int j = n_in - 1; j >= 0; j--) begin
            d[j] = b[7];
            b = b << 1;
         end
         #7.5 sck = 1'b1;
         for (int j = n_out - 1; j >= 0 && k < 8 / n_out; j--)
            r = {r[6:0], io_out[(n_out == 1) ? 1 : j]};
         #7.5;
      end
   endtask
   task automatic stop();
      sck = pol;
      #7.5 cs_n = 1'b1;
      // Released lines show the inverse, never a held copy of the last bit
      d = ~d;
      ni = 1;
      #15;
   endtask
   task automatic junk(input int n);
      repeat (n) begin
         sck = 1'b1;
         d = 4'($urandom);
         #7.5 sck = 1'b0;
         #7.5;
      end
   endtask
endmodule

// ---- tb/test_serial_flash_spi_front_end.sv ----
`timescale 1ns/10ps
module test_serial_flash_spi_front_end;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sck, cs_n, status_write_blocked, selected, frame_end, rx_valid, tx_ready;
   logic [3:0] io_in, io_out, io_oe_n;
   logic quad_lane_enable = 1'b0;
   logic status_protect_bit0 = 1'b0;
   logic tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] r, b, v;
   spi_front_pkg::rx_s rx_word;
   logic [8:0] expq[$];
   int failures = 0;
   int n_checks = 0;
   logic [7:0] ops[6] = '{8'h03, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hEB};
   int nis[6] = '{1, 1, 2, 1, 4, 1};
   int nos[6] = '{1, 2, 2, 4, 4, 1};
   always #5 clk = ~clk;
   serial_flash_spi_front_end u_dut (.clk, .nrst, .sck, .cs_n, .io_in, .io_out, .io_oe_n,
      .quad_lane_enable, .status_protect_bit0, .status_write_blocked, .selected,
      .frame_end, .rx_valid, .rx_word, .tx_data, .tx_valid, .tx_ready);
   flash_host u_host (.sck, .cs_n, .io_in, .io_out);
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic load(input logic [7:0] x);
      @(posedge clk);
      while (tx_ready !== 1'b1) @(posedge clk);
      tx_valid <= 1'b1;
      tx_data <= x;
      @(posedge clk) tx_valid <= 1'b0;
   endtask
   task automatic frame(input int i);
      v = 8'($urandom);
      b = 8'($urandom);
      @(posedge clk) quad_lane_enable <= (i == 3 || i == 4);
      load(v);
      expq.push_back({1'b1, ops[i]});
      expq.push_back({1'b0, b});
      u_host.start(i[0]);
      u_host.xfer(ops[i], 1, 1, 8, r);
      u_host.xfer(b, nis[i], nos[i], 8 / nis[i], r);
      u_host.stop();
      chk({1'b0, r}, {1'b0, v});
   endtask
   always @(posedge clk)
      if (rx_valid === 1'b1) begin
         if (expq.size() == 0)
            chk(9'h000, 9'h100);
         else
            chk(rx_word, expq.pop_front());
      end
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(60));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk({5'h00, io_oe_n}, 9'h00F);
      // Select was already low through reset, so these clocks count for nothing
      u_host.xfer(8'($urandom), 1, 1, 8, r);
      u_host.stop();
      u_host.start(1'b0);
      u_host.xfer(8'hFF, 1, 1, 4, r);
      u_host.stop();
      for (int i = 0; i < 6; i++)
         frame(i);
      @(posedge clk) quad_lane_enable <= 1'b0;
      v = 8'($urandom);
      b = 8'($urandom);
      load(v);
      expq.push_back(9'h103);
      expq.push_back({1'b0, b});
      u_host.start(1'b1);
      u_host.pause_n = 1'b0;
      u_host.junk(3);
      u_host.pause_n = 1'b1;
      u_host.xfer(8'h03, 1, 1, 8, r);
      u_host.sck = 1'b0;
      #7.5 u_host.pause_n = 1'b0;
      #1 chk({5'h00, io_oe_n}, 9'h00F);
      u_host.junk(4);
      u_host.pause_n = 1'b1;
      u_host.xfer(b, 1, 1, 8, r);
      u_host.stop();
      chk({1'b0, r}, {1'b0, v});
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) status_protect_bit0 <= i[0];
         quad_lane_enable <= i[1];
         u_host.wp_n <= i[2];
         repeat (6) @(posedge clk);
         chk({8'h00, status_write_blocked}, {8'h00, i[0] & ~i[1] & ~i[2]});
      end
      repeat (10) @(posedge clk);
      tally_and_finish();
   end
endmodule
